// ==== design/option_word_decoder.v ====
// Option word decoder: holds three option words and latches their fields.
`timescale 1ns/10ps
`include "option_word_decoder_defines.vh"
module option_word_decoder #(
  parameter WORD_W   = 13,
  parameter QUAL_CYC = `OWD_UV_QUAL_CYC
) (
  // Clock and reset.
  input  wire              clk_i,
  input  wire              rst_i,
  // Classic Wishbone slave.
  input  wire              cyc_i,
  input  wire              stb_i,
  input  wire              we_i,
  input  wire [7:0]        adr_i,
  input  wire [3:0]        sel_i,
  input  wire [31:0]       dat_i,
  output reg  [31:0]       dat_o,
  output reg               ack_o,
  // Analog comparator levels from the supply monitor, asynchronous.
  input  wire              below_reset_lvl_i,
  input  wire              above_release_lvl_i,
  // Decoded fields, undervolt reset and core run.
  output reg  [1:0]        undervolt_reset_sel_o,
  output reg               part_valid_o,
  output reg               cycles_per_instr_sel_o,
  output reg               watchdog_en_o,
  output reg  [2:0]        osc_mode_o,
  output reg               osc_pins_dedicated_o,
  output reg               code_protect_o,
  output reg               clock_out_pin_sel_o,
  output reg  [1:0]        rc_freq_sel_o,
  output reg               noise_filter_sel_o,
  output reg               shared_pin_func_sel_o,
  output reg               watchdog_period_sel_o,
  output reg  [5:0]        customer_code_o,
  output reg               reserved_err_o,
  output reg               undervolt_reset_o,
  output reg               core_run_o
);
  // Loader states.
  localparam ST_RD0  = 5'b00001;
  localparam ST_RD1  = 5'b00010;
  localparam ST_RD2  = 5'b00100;
  localparam ST_LAT  = 5'b01000;
  localparam ST_RUN  = 5'b10000;

  reg [4:0]        state_q;
  reg [1:0]        raddr_q;
  reg [WORD_W-1:0] w0_q;
  reg [WORD_W-1:0] w1_q;
  reg [WORD_W-1:0] w2_q;
  reg              reload_req_q;
  reg [2:0]        below_sync_q;
  reg [2:0]        above_sync_q;
  reg              below_q;
  reg              above_q;
  reg [15:0]       qual_cnt_q;
  reg              uv_hold_q;
  wire [WORD_W-1:0] store_rdata;
  wire              store_we;
  wire [1:0]        store_waddr;
  wire              bus_req;
  wire              in_reset;
  wire              rsvd_bad;

  // Crystal modes have the top oscillator bit set.
  function is_crystal;
    input [2:0] mode;
    begin
      is_crystal = mode[2];
    end
  endfunction

  // Word index from a bus address; three marks no word.
  function [1:0] word_index;
    input [7:0] adr;
    begin
      case (adr)
        `OWD_ADR_W0: word_index = 2'd0;
        `OWD_ADR_W1: word_index = 2'd1;
        `OWD_ADR_W2: word_index = 2'd2;
        default:     word_index = 2'd3;
      endcase
    end
  endfunction

  assign bus_req     = cyc_i && stb_i && !ack_o;
  assign store_waddr = word_index(adr_i);
  // Writes land only in the low lanes and only while the core is held.
  assign store_we    = bus_req && we_i && sel_i[0] && sel_i[1] &&
                       !core_run_o;
  assign in_reset    = (state_q != ST_RUN);

  // Register map, one 32-bit word per access with the data in the low bits.
  // Offsets 0x00, 0x04 and 0x08 hold words 0 to 2, and reads return the
  // latched copy. 0x0C is status, 0x10 packs the decoded fields and bit 0
  // of 0x14 asks for a reload. Unmapped offsets acknowledge, read zero and
  // drop writes.
  // Word writes are refused while the core runs. A word changed under a
  // running core would only land at the next reload, and it could then
  // switch the oscillator without the software expecting it.

  // Fixed bits or the trim field left wrong by the programmer.
  // The check is only a flag; the fields still decode, because a bad
  // fixed bit does not by itself make the other fields meaningless.
  assign rsvd_bad =
    ((w0_q & `OWD_W0_RSVD_MASK) != `OWD_W0_RSVD_VAL) ||
    ((w1_q & `OWD_W1_RSVD_MASK) != `OWD_W1_RSVD_VAL) ||
    ((w2_q & `OWD_W2_RSVD_MASK) != `OWD_W2_RSVD_VAL) ||
    (w1_q[`OWD_W1_TRIM_HI:`OWD_W1_TRIM_LO] != 4'hF);

  // Separate store for the three option words.
  option_word_store #(
    .WORD_W (WORD_W)
  ) u_store (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .we_i    (store_we),
    .waddr_i (store_waddr),
    .wdata_i (dat_i[WORD_W-1:0]),
    .raddr_i (raddr_q),
    .rdata_o (store_rdata)
  );

  // Three-stage synchronisers; a level change counts when stages agree.
  // The comparators settle on their own time base. Waiting for the last
  // two stages to agree costs three to four cycles of latency, but keeps
  // a single-cycle spike from reaching the qualifying counter. The release
  // stages reset high so that a good supply shows no false edge at start.
  always @(posedge clk_i) begin
    if (rst_i) begin
      below_sync_q <= 3'b000;
      above_sync_q <= 3'b111;
      below_q      <= 1'b0;
      above_q      <= 1'b1;
    end else begin
      below_sync_q <= {below_sync_q[1:0], below_reset_lvl_i};
      above_sync_q <= {above_sync_q[1:0], above_release_lvl_i};
      if (below_sync_q[1] == below_sync_q[2]) begin
        below_q <= below_sync_q[2];
      end
      if (above_sync_q[1] == above_sync_q[2]) begin
        above_q <= above_sync_q[2];
      end
    end
  end

  // Undervolt reset: qualify low supply, then hold until release level.
  // The counter restarts on any good sample, so a dip shorter than the
  // qualifying time never trips. The qualifying time is a parameter
  // because it is a count of clock cycles, not a fixed time.
  // A disabled selection never trips, so power-on reset alone applies.
  always @(posedge clk_i) begin
    if (rst_i) begin
      qual_cnt_q <= 16'h0000;
      uv_hold_q  <= 1'b0;
    end else if (undervolt_reset_sel_o == `OWD_UV_NONE) begin
      qual_cnt_q <= 16'h0000;
      uv_hold_q  <= 1'b0;
    end else if (uv_hold_q) begin
      qual_cnt_q <= 16'h0000;
      if (above_q) begin
        uv_hold_q <= 1'b0;
      end
    end else if (below_q) begin
      if (qual_cnt_q >= QUAL_CYC[15:0] - 16'h0001) begin
        uv_hold_q  <= 1'b1;
        qual_cnt_q <= 16'h0000;
      end else begin
        qual_cnt_q <= qual_cnt_q + 16'h0001;
      end
    end else begin
      qual_cnt_q <= 16'h0000;
    end
  end

  // Loader: reads each word during reset, then latches all fields at once.
  // Fields stay frozen in run, so a mode never changes mid-operation.
  // The store answers one cycle after its address, so each word is taken
  // two states after the one that set its address.
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= ST_RD0;
      raddr_q <= 2'd0;
      w0_q    <= `OWD_W0_DEFAULT;
      w1_q    <= `OWD_W1_DEFAULT;
      w2_q    <= `OWD_W2_DEFAULT;
    end else begin
      case (state_q)
        ST_RD0: begin
          raddr_q <= 2'd1;
          state_q <= ST_RD1;
        end
        ST_RD1: begin
          w0_q    <= store_rdata;
          raddr_q <= 2'd2;
          state_q <= ST_RD2;
        end
        ST_RD2: begin
          w1_q    <= store_rdata;
          state_q <= ST_LAT;
        end
        ST_LAT: begin
          w2_q    <= store_rdata;
          state_q <= ST_RUN;
        end
        ST_RUN: begin
          if (uv_hold_q || reload_req_q) begin
            raddr_q <= 2'd0;
            state_q <= ST_RD0;
          end
        end
        default: begin
          state_q <= ST_RD0;
        end
      endcase
    end
  end

  // Field decode, updated only in ST_RUN while core_run_o is still low.
  always @(posedge clk_i) begin
    if (rst_i) begin
      undervolt_reset_sel_o  <= 2'b11;
      part_valid_o           <= 1'b1;
      cycles_per_instr_sel_o <= 1'b1;
      watchdog_en_o          <= 1'b0;
      osc_mode_o             <= `OWD_OSC_HIGH_CRYSTAL_MODE_B;
      osc_pins_dedicated_o   <= 1'b1;
      code_protect_o         <= 1'b0;
      // The default mode is a crystal mode, which keeps the clock output off.
      clock_out_pin_sel_o    <= 1'b0;
      rc_freq_sel_o          <= 2'b11;
      noise_filter_sel_o     <= 1'b1;
      shared_pin_func_sel_o  <= 1'b1;
      watchdog_period_sel_o  <= 1'b1;
      customer_code_o        <= 6'h3F;
      reserved_err_o         <= 1'b0;
    end else if (state_q == ST_RUN && in_reset == 1'b0 &&
                 core_run_o == 1'b0) begin
      undervolt_reset_sel_o  <= w0_q[`OWD_W0_UV_HI:`OWD_W0_UV_LO];
      part_valid_o           <= (w0_q[`OWD_W0_PART_HI:`OWD_W0_PART_LO]
                                 == `OWD_PART_VALID);
      cycles_per_instr_sel_o <= w0_q[`OWD_W0_CPI];
      watchdog_en_o          <= ~w0_q[`OWD_W0_WDT_DIS_N];
      osc_mode_o             <= w0_q[`OWD_W0_OSC_HI:`OWD_W0_OSC_LO];
      osc_pins_dedicated_o   <= is_crystal(
                                  w0_q[`OWD_W0_OSC_HI:`OWD_W0_OSC_LO]);
      // Any cleared protect bit engages protection.
      code_protect_o         <= ~&w0_q[`OWD_W0_PROT_HI:`OWD_W0_PROT_LO];
      // Clock-out choice only matters in RC modes; crystal forces it low.
      clock_out_pin_sel_o    <= w1_q[`OWD_W1_CLKOUT] &
                                ~is_crystal(
                                  w0_q[`OWD_W0_OSC_HI:`OWD_W0_OSC_LO]);
      rc_freq_sel_o          <= w1_q[`OWD_W1_RCF_HI:`OWD_W1_RCF_LO];
      noise_filter_sel_o     <= w2_q[`OWD_W2_NOISE];
      shared_pin_func_sel_o  <= w2_q[`OWD_W2_PINFUNC];
      watchdog_period_sel_o  <= w2_q[`OWD_W2_WDTPER];
      customer_code_o        <= w2_q[`OWD_W2_ID_HI:`OWD_W2_ID_LO];
      // Flag words the programmer left with bad fixed bits or trim.
      reserved_err_o         <= rsvd_bad;
    end
  end

  // Core run and undervolt outputs. Run starts on the same edge that latches the fields.
  always @(posedge clk_i) begin
    if (rst_i) begin
      core_run_o        <= 1'b0;
      undervolt_reset_o <= 1'b0;
    end else begin
      undervolt_reset_o <= uv_hold_q;
      core_run_o        <= (state_q == ST_RUN) && !uv_hold_q &&
                           !reload_req_q && core_run_o_next_ok(state_q);
    end
  end

  // Run may be granted once the loader has been in run for a cycle.
  function core_run_o_next_ok;
    input [4:0] st;
    begin
      core_run_o_next_ok = (st == ST_RUN);
    end
  endfunction

  // Wishbone slave: one-cycle registered answer, unmapped reads zero.
  // Read data is zero outside the acknowledge cycle, so a master that
  // samples a cycle late sees zero rather than stale data.
  // Control bit 0 requests a reload of the words into the decoder.
  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o        <= 1'b0;
      dat_o        <= 32'h0000_0000;
      reload_req_q <= 1'b0;
    end else begin
      ack_o <= bus_req;
      if (state_q == ST_RD0) begin
        reload_req_q <= 1'b0;
      end
      if (bus_req && we_i && adr_i == `OWD_ADR_CTRL && sel_i[0] &&
          dat_i[0]) begin
        reload_req_q <= 1'b1;
      end
      dat_o <= 32'h0000_0000;
      if (bus_req && !we_i) begin
        case (adr_i)
          `OWD_ADR_W0:   dat_o <= {19'h0_0000, w0_q};
          `OWD_ADR_W1:   dat_o <= {19'h0_0000, w1_q};
          `OWD_ADR_W2:   dat_o <= {19'h0_0000, w2_q};
          `OWD_ADR_STAT: dat_o <= {27'h000_0000, reserved_err_o,
                                   part_valid_o, uv_hold_q,
                                   in_reset, core_run_o};
          `OWD_ADR_DEC:  dat_o <= {12'h000, customer_code_o,
                                   watchdog_period_sel_o,
                                   shared_pin_func_sel_o,
                                   noise_filter_sel_o, rc_freq_sel_o,
                                   clock_out_pin_sel_o, code_protect_o,
                                   osc_mode_o, watchdog_en_o,
                                   cycles_per_instr_sel_o,
                                   undervolt_reset_sel_o};
          `OWD_ADR_CTRL: dat_o <= {31'h0000_0000, reload_req_q};
          default:       dat_o <= 32'h0000_0000;
        endcase
      end
    end
  end
endmodule // option_word_decoder

// ==== design/option_word_decoder_defines.vh ====
// Constants for the option word decoder: field positions, defaults, timings.
`ifndef OPTION_WORD_DECODER_DEFINES_VH
`define OPTION_WORD_DECODER_DEFINES_VH
`define OWD_WORD_W          13
`define OWD_W0_UV_HI        12
`define OWD_W0_UV_LO        11
`define OWD_W0_PART_HI      10
`define OWD_W0_PART_LO      9
`define OWD_W0_CPI          8
`define OWD_W0_WDT_DIS_N    7
`define OWD_W0_OSC_HI       6
`define OWD_W0_OSC_LO       4
`define OWD_W0_PROT_HI      2
`define OWD_W0_PROT_LO      0
`define OWD_W1_CLKOUT       9
`define OWD_W1_TRIM_HI      5
`define OWD_W1_TRIM_LO      2
`define OWD_W1_RCF_HI       1
`define OWD_W1_RCF_LO       0
`define OWD_W2_NOISE        9
`define OWD_W2_PINFUNC      8
`define OWD_W2_WDTPER       6
`define OWD_W2_ID_HI        5
`define OWD_W2_ID_LO        0
`define OWD_W0_DEFAULT      13'h1_FF7
`define OWD_W1_DEFAULT      13'h0_E7F
`define OWD_W2_DEFAULT      13'h1_BFF
`define OWD_W0_RSVD_MASK    13'h0_008
`define OWD_W0_RSVD_VAL     13'h0_000
`define OWD_W1_RSVD_MASK    13'h1_DC0
`define OWD_W1_RSVD_VAL     13'h0_C40
`define OWD_W2_RSVD_MASK    13'h1_C80
`define OWD_W2_RSVD_VAL     13'h1_880
`define OWD_PART_VALID      2'h1
`define OWD_UV_NONE         2'h3
`define OWD_OSC_ERC_IO      3'h0
`define OWD_OSC_ERC_OUT     3'h1
`define OWD_OSC_IRC_IO      3'h2
`define OWD_OSC_IRC_OUT     3'h3
`define OWD_OSC_LOW_CRYSTAL_MODE_A        3'h4
`define OWD_OSC_HIGH_CRYSTAL_MODE_A        3'h5
`define OWD_OSC_WATCH_CRYSTAL_MODE        3'h6
`define OWD_OSC_HIGH_CRYSTAL_MODE_B        3'h7
`define OWD_CLK_HZ          50000000
`define OWD_UV_QUAL_NS      10000
`define OWD_UV_QUAL_CYC     ((`OWD_UV_QUAL_NS * (`OWD_CLK_HZ / 1000000) + 999) / 1000)
`define OWD_ADR_W0          8'h00
`define OWD_ADR_W1          8'h04
`define OWD_ADR_W2          8'h08
`define OWD_ADR_STAT        8'h0C
`define OWD_ADR_DEC         8'h10
`define OWD_ADR_CTRL        8'h14
`endif

// ==== design/option_word_store.v ====
// Three-word option store with registered read port.
`timescale 1ns/10ps
`include "option_word_decoder_defines.vh"
module option_word_store #(
  parameter WORD_W = 13
) (
  // Clock and reset.
  input  wire              clk_i,
  input  wire              rst_i,
  // Write port, used by the programmer path.
  input  wire              we_i,
  input  wire [1:0]        waddr_i,
  input  wire [WORD_W-1:0] wdata_i,
  // Read port.
  input  wire [1:0]        raddr_i,
  output reg  [WORD_W-1:0] rdata_o
);
  reg [WORD_W-1:0] mem_q [0:2];

  // Words return to their erased defaults at reset; a word index of three
  // is ignored on write and reads zero.
  always @(posedge clk_i) begin
    if (rst_i) begin
      mem_q[0] <= `OWD_W0_DEFAULT;
      mem_q[1] <= `OWD_W1_DEFAULT;
      mem_q[2] <= `OWD_W2_DEFAULT;
      rdata_o  <= {WORD_W{1'b0}};
    end else begin
      if (we_i && waddr_i != 2'd3) begin
        mem_q[waddr_i] <= wdata_i;
      end
      rdata_o <= (raddr_i == 2'd3) ? {WORD_W{1'b0}} : mem_q[raddr_i];
    end
  end
endmodule // option_word_store

// ==== verif/option_programmer.sv ====
// Programmer model that burns option words over the register bus.
`timescale 1ns/10ps
`include "option_word_decoder_defines.vh"
module option_programmer (
  // Clock.
  input  logic        clk_i,
  // Register bus towards the decoder.
  output logic        cyc_o,
  output logic        stb_o,
  output logic        we_o,
  output logic [7:0]  adr_o,
  output logic [3:0]  sel_o,
  output logic [31:0] dat_o,
  input  logic [31:0] rdat_i,
  input  logic        ack_i
);
  logic hung;

  // The bus is idle at time zero.
  initial begin
    cyc_o = 1'b0;
    stb_o = 1'b0;
    we_o = 1'b0;
    adr_o = 8'h00;
    sel_o = 4'h0;
    dat_o = 32'h0000_0000;
    hung = 1'b0;
  end

  // One classic cycle; released lines show inverted values, not stale ones.
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [3:0] s,
                      output logic [31:0] q);
    int n;
    n = 0;
    cyc_o <= 1'b1;
    stb_o <= 1'b1;
    we_o <= w;
    adr_o <= a;
    sel_o <= s;
    dat_o <= d;
    @(posedge clk_i);
    while (ack_i !== 1'b1 && n < 100) begin
      n++;
      @(posedge clk_i);
    end
    q = rdat_i;
    hung = ack_i !== 1'b1;
    cyc_o <= 1'b0;
    stb_o <= 1'b0;
    we_o <= ~w;
    adr_o <= ~a;
    sel_o <= ~s;
    dat_o <= ~d;
    @(posedge clk_i);
  endtask

  // Fixed bits and the trim field always go in at their set values; bad
  // flips bit 3, which is a fault when burned into word 0 or into the trim field of word 1.
  task automatic burn(input logic [1:0] k, input logic [12:0] w,
                      input logic bad, output logic [31:0] q);
    logic [12:0] m;
    logic [12:0] v;
    m = k == 2'h0 ? `OWD_W0_RSVD_MASK : k == 2'h1 ?
        (`OWD_W1_RSVD_MASK | 13'h003c) : `OWD_W2_RSVD_MASK;
    v = k == 2'h0 ? `OWD_W0_RSVD_VAL : k == 2'h1 ?
        (`OWD_W1_RSVD_VAL | 13'h003c) : `OWD_W2_RSVD_VAL;
    v = ((w & ~m) | v) ^ {9'h000, bad, 3'h0};
    xfer(1'b1, {4'h0, k, 2'h0}, {19'h0_0000, v}, 4'hf, q);
  endtask
endmodule // option_programmer

// ==== verif/option_word_decoder_assertions.sv ====
// Concurrent checks on the ports of the option word decoder.
`timescale 1ns/10ps
`include "option_word_decoder_defines.vh"
module option_word_decoder_assertions #(
  parameter QUAL_CYC = 500
) (
  // Clock and reset.
  input logic        clk_i,
  input logic        rst_i,
  // Register bus.
  input logic        cyc_i,
  input logic        stb_i,
  input logic        we_i,
  input logic [7:0]  adr_i,
  input logic [31:0] dat_o,
  input logic        ack_o,
  // Supply comparators.
  input logic        below_reset_lvl_i,
  input logic        above_release_lvl_i,
  // Decoded fields and core state.
  input logic [1:0]  undervolt_reset_sel_o,
  input logic        part_valid_o,
  input logic        cycles_per_instr_sel_o,
  input logic        watchdog_en_o,
  input logic [2:0]  osc_mode_o,
  input logic        osc_pins_dedicated_o,
  input logic        code_protect_o,
  input logic        clock_out_pin_sel_o,
  input logic [1:0]  rc_freq_sel_o,
  input logic        noise_filter_sel_o,
  input logic        shared_pin_func_sel_o,
  input logic        watchdog_period_sel_o,
  input logic [5:0]  customer_code_o,
  input logic        reserved_err_o,
  input logic        undervolt_reset_o,
  input logic        core_run_o
);
  int unsigned below_cnt_q;
  logic [19:0] fields_w;

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Fields packed in the order of the decoded-field register.
  assign fields_w = {customer_code_o, watchdog_period_sel_o,
    shared_pin_func_sel_o, noise_filter_sel_o, rc_freq_sel_o,
    clock_out_pin_sel_o, code_protect_o, osc_mode_o, watchdog_en_o,
    cycles_per_instr_sel_o, undervolt_reset_sel_o};

  // Counts a steady low supply; saturation keeps a long brown-out safe.
  always @(posedge clk_i) begin
    if (rst_i || !below_reset_lvl_i || above_release_lvl_i)
      below_cnt_q <= 0;
    else if (below_cnt_q < QUAL_CYC + 16)
      below_cnt_q <= below_cnt_q + 1;
  end

  sequence bus_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence supply_good;
    (above_release_lvl_i && !below_reset_lvl_i) [*8];
  endsequence

  req_ack_a: assert property (bus_req |=> ack_o)
    else $error("request not acknowledged in the next cycle");
  ack_pulse_a: assert property (ack_o |=> !ack_o)
    else $error("ack held longer than one cycle");
  dat_idle_a: assert property (!ack_o |-> dat_o == 32'h0000_0000)
    else $error("read data not zero outside ack");
  dec_read_a: assert property (ack_o && !we_i && adr_i == `OWD_ADR_DEC
    |-> dat_o[19:0] == fields_w)
    else $error("decoded register disagrees with field outputs");
  pins_dedicated_a:
    assert property (osc_pins_dedicated_o == osc_mode_o[2])
    else $error("oscillator pin use disagrees with mode");
  clkout_xtal_a:
    assert property (core_run_o && osc_mode_o[2] |-> !clock_out_pin_sel_o)
    else $error("clock output enabled in a crystal mode");
  fields_hold_a:
    assert property (!$rose(core_run_o)
      |-> $stable({fields_w, reserved_err_o, part_valid_o}))
    else $error("decoded field changed while running");
  boot_run_a:
    assert property ($fell(rst_i) |-> ##[3:8] core_run_o)
    else $error("core did not start after reset");
  uv_refused_a:
    assert property (undervolt_reset_sel_o == 2'h3 && !undervolt_reset_o
      |=> !undervolt_reset_o)
    else $error("undervolt reset with monitor disabled");
  uv_trip_a:
    assert property (below_cnt_q == QUAL_CYC + 8
      && undervolt_reset_sel_o != 2'h3 |-> undervolt_reset_o)
    else $error("low supply did not trip undervolt reset");
  uv_hold_a:
    assert property (undervolt_reset_o [*2] |-> !core_run_o)
    else $error("core running during undervolt reset");
  uv_release_a:
    assert property (supply_good |-> !undervolt_reset_o)
    else $error("undervolt reset not released");
endmodule // option_word_decoder_assertions

bind option_word_decoder option_word_decoder_assertions #(
  .QUAL_CYC(QUAL_CYC)
) chk_inst (
  .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .dat_o, .ack_o,
  .below_reset_lvl_i, .above_release_lvl_i, .undervolt_reset_sel_o,
  .part_valid_o, .cycles_per_instr_sel_o, .watchdog_en_o, .osc_mode_o,
  .osc_pins_dedicated_o, .code_protect_o, .clock_out_pin_sel_o,
  .rc_freq_sel_o, .noise_filter_sel_o, .shared_pin_func_sel_o,
  .watchdog_period_sel_o, .customer_code_o, .reserved_err_o,
  .undervolt_reset_o, .core_run_o
);

// ==== verif/option_word_decoder_tb_top.sv ====
// Self-checking bench for the option word decoder.
`timescale 1ns/10ps
`include "option_word_decoder_defines.vh"
module option_word_decoder_tb_top;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o;
  logic        below_reset_lvl_i, above_release_lvl_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i, dat_o, rd, seed, fields_w;
  logic [1:0]  undervolt_reset_sel_o, rc_freq_sel_o;
  logic [2:0]  osc_mode_o;
  logic [5:0]  customer_code_o;
  logic        part_valid_o, cycles_per_instr_sel_o, watchdog_en_o;
  logic        osc_pins_dedicated_o, code_protect_o, clock_out_pin_sel_o;
  logic        noise_filter_sel_o, shared_pin_func_sel_o, reserved_err_o;
  logic        watchdog_period_sel_o, undervolt_reset_o, core_run_o;
  int          n_fail = 0;
  int          n_checks = 0;

  // A short qualifying time keeps brown-out scenarios brief.
  option_word_decoder #(.QUAL_CYC(5)) option_word_decoder_inst (
    .clk_i, .rst_i, .cyc_i, .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o,
    .ack_o, .below_reset_lvl_i, .above_release_lvl_i, .undervolt_reset_sel_o,
    .part_valid_o, .cycles_per_instr_sel_o, .watchdog_en_o, .osc_mode_o,
    .osc_pins_dedicated_o, .code_protect_o, .clock_out_pin_sel_o,
    .rc_freq_sel_o, .noise_filter_sel_o, .shared_pin_func_sel_o,
    .watchdog_period_sel_o, .customer_code_o, .reserved_err_o,
    .undervolt_reset_o, .core_run_o);

  option_programmer option_programmer_inst (.clk_i, .cyc_o(cyc_i),
    .stb_o(stb_i), .we_o(we_i), .adr_o(adr_i), .sel_o(sel_i), .dat_o(dat_i),
    .rdat_i(dat_o), .ack_i(ack_o));

  // Field outputs packed like the decoded-field register.
  assign fields_w = {12'h000, customer_code_o, watchdog_period_sel_o,
    shared_pin_func_sel_o, noise_filter_sel_o, rc_freq_sel_o,
    clock_out_pin_sel_o, code_protect_o, osc_mode_o, watchdog_en_o,
    cycles_per_instr_sel_o, undervolt_reset_sel_o};

  // A 50 MHz clock.
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  // Expected fields; crystal modes force the clock output off.
  function automatic logic [31:0] dec(input logic [12:0] a, b, c);
    dec = {12'h000, c[5:0], c[6], c[8], c[9], b[1:0], b[9] & ~a[6],
           a[2:0] != 3'h7, a[6:4], ~a[7], a[8], a[12:11]};
  endfunction

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic give_up;
    n_fail++;
    tally_and_finish();
  endtask

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic [3:0] s);
    option_programmer_inst.xfer(w, a, d, s, rd);
    if (option_programmer_inst.hung) give_up();
  endtask

  task automatic wait_for(input logic uv, input logic v);
    int n;
    n = 0;
    while ((uv ? undervolt_reset_o : core_run_o) !== v) begin
      if (n == 300) give_up();
      n++;
      @(posedge clk_i);
    end
  endtask

  // The store takes words only while the core is held, so each burn rides
  // its own reload window; a last reload latches all three together.
  task automatic load_words(input logic [12:0] w0, w1, w2,
                            input logic bad);
    logic [12:0] w [3];
    w = '{w0, w1, w2};
    for (int k = 0; k < 3; k++) begin
      bus(1'b1, `OWD_ADR_CTRL, 32'h0000_0001, 4'hf);
      wait_for(1'b0, 1'b0);
      option_programmer_inst.burn(k[1:0], w[k], bad && k == 0, rd);
      if (option_programmer_inst.hung) give_up();
    end
    bus(1'b1, `OWD_ADR_CTRL, 32'h0000_0001, 4'hf);
    wait_for(1'b0, 1'b0);
    wait_for(1'b0, 1'b1);
  endtask

  // Main sequence.
  initial begin
    logic [12:0] a, b, c;
    rst_i = 1'b1;
    below_reset_lvl_i = 1'b0;
    above_release_lvl_i = 1'b1;
    seed = 32'h0000_b0ed;
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_for(1'b0, 1'b1);
    a = `OWD_W0_DEFAULT;
    b = `OWD_W1_DEFAULT;
    c = `OWD_W2_DEFAULT;
    cmp(fields_w, dec(a, b, c));
    bus(1'b0, `OWD_ADR_DEC, 32'h0000_0000, 4'hf);
    cmp(rd, dec(a, b, c));
    cmp({31'h0, part_valid_o}, {31'h0, a[10:9] == 2'h1});
    bus(1'b1, 8'h20, 32'hffff_ffff, 4'h5);
    bus(1'b0, 8'h20, 32'h0000_0000, 4'hf);
    cmp(rd, 32'h0000_0000);
    bus(1'b1, `OWD_ADR_W0, 32'h0000_0000, 4'hf);
    bus(1'b0, `OWD_ADR_W0, 32'h0000_0000, 4'hf);
    cmp(rd, {19'h0_0000, a});
    $display("test defaults done");
    for (int i = 0; i < 9; i++) begin
      seed = lfsr(seed);
      a = seed[12:0];
      seed = lfsr(seed);
      b = seed[12:0];
      seed = lfsr(seed);
      c = seed[12:0];
      if (i < 8) a[6:4] = i[2:0];
      b[1:0] = i[1:0];
      load_words(a, b, c, i == 8);
      cmp(fields_w, dec(a, b, c));
      bus(1'b0, `OWD_ADR_DEC, 32'h0000_0000, 4'hf);
      cmp(rd, dec(a, b, c));
      cmp({reserved_err_o, part_valid_o}, {i == 8, a[10:9] == 2'h1});
      $display("test random words %0d done", i);
    end
    // With the monitor off a low supply must change nothing.
    load_words(`OWD_W0_DEFAULT, `OWD_W1_DEFAULT, `OWD_W2_DEFAULT, 1'b0);
    below_reset_lvl_i <= 1'b1;
    above_release_lvl_i <= 1'b0;
    repeat (40) @(posedge clk_i);
    cmp({undervolt_reset_o, core_run_o}, 32'h0000_0001);
    below_reset_lvl_i <= 1'b0;
    above_release_lvl_i <= 1'b1;
    load_words(13'h17f7, `OWD_W1_DEFAULT, `OWD_W2_DEFAULT, 1'b0);
    cmp({30'h0, undervolt_reset_sel_o}, 32'h0000_0002);
    below_reset_lvl_i <= 1'b1;
    above_release_lvl_i <= 1'b0;
    wait_for(1'b1, 1'b1);
    repeat (2) @(posedge clk_i);
    cmp({undervolt_reset_o, core_run_o}, 32'h0000_0002);
    below_reset_lvl_i <= 1'b0;
    above_release_lvl_i <= 1'b1;
    wait_for(1'b1, 1'b0);
    wait_for(1'b0, 1'b1);
    $display("test undervolt done");
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    cmp(fields_w, dec(`OWD_W0_DEFAULT, `OWD_W1_DEFAULT,
                      `OWD_W2_DEFAULT));
    rst_i <= 1'b0;
    wait_for(1'b0, 1'b1);
    $display("test second reset done");
    tally_and_finish();
  end
endmodule // option_word_decoder_tb_top
